// >>> design/pwmss_map.svh
// constants for the pwm period-synchronisation block
// assumes inclusion by the package and the design module only
`ifndef PWMSS_MAP_SVH
`define PWMSS_MAP_SVH
`define PWMSS_CNT_W 16
`define PWMSS_DLY_W 16
`define PWMSS_NCAP 3
`define PWMSS_NMAT 6
`define PWMSS_CNT_ZERO 16'h0000
`define PWMSS_CNT_ONE 16'h0001
`define PWMSS_DLY_TWO 16'h0002
`endif

// >>> design/pwmss_pkg.sv
// types for the pwm period-synchronisation block
// assumes pwmss_map.svh is on the include path
package pwmss_pkg;
`include "pwmss_map.svh"
  typedef struct packed {
    logic start;
    logic load;
  } pwmss_sync_t;
  typedef enum logic [1:0] {
    PWMSS_IDLE = 2'b01,
    PWMSS_WAIT = 2'b10
  } pwmss_state_t;
  typedef struct packed {
    logic [`PWMSS_CNT_W-1:0] pre;
    logic [`PWMSS_CNT_W-1:0] cnt;
    logic [`PWMSS_DLY_W-1:0] dly;
    pwmss_state_t st;
    logic pend_load;
    pwmss_sync_t sync_out;
    logic [`PWMSS_NMAT-1:0] mat;
    logic [`PWMSS_NMAT-1:0][`PWMSS_CNT_W-1:0] rise_sh;
    logic [`PWMSS_NMAT-1:0][`PWMSS_CNT_W-1:0] fall_sh;
    logic [`PWMSS_CNT_W-1:0] per_sh;
    logic [`PWMSS_CNT_W-1:0] pre_sh;
    logic [`PWMSS_NCAP-1:0] cap_d;
    logic [`PWMSS_NCAP-1:0][`PWMSS_CNT_W-1:0] cap_val;
    logic fault;
  } pwmss_state_s_t;
endpackage : pwmss_pkg

// >>> design/pwmss_core.sv
// pwm module period counter with master/slave sync pulses, six outputs,
// capture and optional fault. assumes settings are held steady by the
// surrounding logic and sync inputs come from the preceding instance.
// Function
// [RQ1] master emits one-cycle period-start pulse at every counter restart
// [RQ2] shadow-load pulse goes with start pulse only when shadow copy happened
// [RQ3] optional programmable delay before both outgoing pulses
// [RQ4] slave restarts its counter on incoming period-start pulse
// [RQ5] slave copies shadow registers on incoming shadow-load pulse
// [RQ6] instances chain by index; slave inputs come from previous outputs
// [RQ7] three capture inputs beside the match outputs
// [RQ8] fault input exists only on instances two and three
// [RQ9] counters and register side share one clock
// [RQ10] six independently programmed pwm outputs on match pins
// [RQ11] 16-bit prescaler feeds 16-bit counter; restart is sync reference
// [RQ12] delay counts module clocks; zero emits in the restart cycle
// [RQ13] sync inputs ignored when slave disabled; own period restarts then
`timescale 1ns/1ps
module pwmss_core
  import pwmss_pkg::*;
#(
  parameter int INST = 2,
  parameter int CNT_W = `PWMSS_CNT_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic slave_en_i,
  input wire logic upd_req_i,
  input wire logic [`PWMSS_DLY_W-1:0] sync_dly_i,
  input wire logic [CNT_W-1:0] presc_i,
  input wire logic [CNT_W-1:0] period_i,
  input wire logic [`PWMSS_NMAT-1:0][CNT_W-1:0] rise_i,
  input wire logic [`PWMSS_NMAT-1:0][CNT_W-1:0] fall_i,
  input wire pwmss_sync_t sync_i,
  input wire logic [`PWMSS_NCAP-1:0] capture_pin_i,
  input wire logic fault_input_pin_i,
  output pwmss_sync_t sync_o,
  output logic [`PWMSS_NMAT-1:0] match_pin_o,
  output logic [`PWMSS_NCAP-1:0][CNT_W-1:0] cap_val_o,
  output logic fault_o
);
  localparam bit HAS_FAULT = (INST == 2) || (INST == 3);
  pwmss_state_s_t s_r;
  pwmss_state_s_t s_nxt;
  logic pre_tick;
  logic restart;
  logic copy;

  function automatic logic at_end(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
    at_end = (v >= lim);
  endfunction : at_end

  always_comb begin
    s_nxt = s_r;
    pre_tick = run_i && at_end(s_r.pre, s_r.pre_sh); // RQ11
    // slave ignores the chain when disabled and free-runs on its period
    if (slave_en_i) begin
      restart = run_i && sync_i.start; // RQ4 RQ6 RQ13
      copy = restart && sync_i.load; // RQ5
    end else begin
      restart = pre_tick && at_end(s_r.cnt, s_r.per_sh); // RQ13
      copy = restart && upd_req_i; // RQ2
    end
    s_nxt.sync_out = '0;
    if (run_i) begin
      s_nxt.pre = pre_tick ? `PWMSS_CNT_ZERO : CNT_W'(s_r.pre + `PWMSS_CNT_ONE); // RQ9
    end
    if (restart) begin
      s_nxt.cnt = `PWMSS_CNT_ZERO; // RQ11
      s_nxt.pre = `PWMSS_CNT_ZERO;
    end else if (pre_tick) begin
      s_nxt.cnt = CNT_W'(s_r.cnt + `PWMSS_CNT_ONE);
    end
    if (copy) begin
      s_nxt.rise_sh = rise_i;
      s_nxt.fall_sh = fall_i;
      s_nxt.per_sh = period_i;
      s_nxt.pre_sh = presc_i;
    end
    // a restart during a pending delay retriggers it; older pulse is dropped
    if (restart) begin
      if (sync_dly_i == `PWMSS_CNT_ZERO) begin
        s_nxt.sync_out.start = 1'b1; // RQ1 RQ12
        s_nxt.sync_out.load = copy; // RQ2
        s_nxt.st = PWMSS_IDLE;
      end else begin
        s_nxt.dly = sync_dly_i; // RQ3
        s_nxt.pend_load = copy;
        s_nxt.st = PWMSS_WAIT;
      end
    end else begin
      unique case (s_r.st)
        PWMSS_IDLE: begin
        end
        PWMSS_WAIT: begin
          s_nxt.dly = `PWMSS_DLY_W'(s_r.dly - `PWMSS_CNT_ONE);
          if (s_r.dly == `PWMSS_CNT_ONE) begin
            s_nxt.sync_out.start = 1'b1; // RQ3 RQ12
            s_nxt.sync_out.load = s_r.pend_load; // RQ2
            s_nxt.st = PWMSS_IDLE;
          end
        end
        default: s_nxt.st = PWMSS_IDLE;
      endcase
    end
    for (int i = 0; i < `PWMSS_NMAT; i++) begin
      if (s_nxt.cnt == s_nxt.rise_sh[i]) s_nxt.mat[i] = 1'b1; // RQ10
      if (s_nxt.cnt == s_nxt.fall_sh[i]) s_nxt.mat[i] = 1'b0; // RQ10
      if (s_nxt.fault) s_nxt.mat[i] = 1'b0;
    end
    s_nxt.cap_d = capture_pin_i;
    for (int i = 0; i < `PWMSS_NCAP; i++) begin
      if (capture_pin_i[i] && !s_r.cap_d[i]) s_nxt.cap_val[i] = s_r.cnt; // RQ7
    end
    s_nxt.fault = HAS_FAULT && fault_input_pin_i; // RQ8
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= '0;
      s_r.st <= PWMSS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.sync_out;
  assign match_pin_o = s_r.mat;
  assign cap_val_o = s_r.cap_val;
  assign fault_o = s_r.fault;

  sequence seq_restart_nodly;
    restart && sync_dly_i == `PWMSS_CNT_ZERO;
  endsequence

  // own period end, only meaningful while the chain is not followed
  sequence seq_master_end;
    !slave_en_i && pre_tick && at_end(s_r.cnt, s_r.per_sh);
  endsequence

  sequence seq_slave_start;
    slave_en_i && run_i && sync_i.start;
  endsequence

  AST_START_ONE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ1
    sync_o.start |=> !sync_o.start || $past(restart))
    else $error("start pulse held without restart");
  AST_ZERO_DLY: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ12
    seq_restart_nodly |=> sync_o.start)
    else $error("zero delay pulse missing");
  AST_LOAD_WITH_START: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ2
    sync_o.load |-> sync_o.start)
    else $error("load pulse without start pulse");
  AST_NOCOPY_NOLOAD: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ2
    seq_restart_nodly and !copy |=> !sync_o.load)
    else $error("load pulse without copy");
  AST_DLY_TWO: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ3
    restart && sync_dly_i == `PWMSS_DLY_TWO ##1 !restart [*2] |=> sync_o.start)
    else $error("delayed pulse late");
  AST_SLAVE_RST: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ4
    slave_en_i && run_i && sync_i.start |=> s_r.cnt == `PWMSS_CNT_ZERO)
    else $error("slave did not restart");
  AST_SLAVE_COPY: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ5
    slave_en_i && run_i && sync_i.start && sync_i.load |=> s_r.per_sh == $past(period_i))
    else $error("slave shadow copy missing");
  AST_IGNORE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ13
    !slave_en_i && sync_i.start && s_r.cnt != `PWMSS_CNT_ZERO && s_r.cnt < s_r.per_sh
    |=> s_r.cnt != `PWMSS_CNT_ZERO)
    else $error("disabled slave obeyed sync");
  AST_FAULT: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ8
    1'b1 |=> fault_o == (HAS_FAULT && $past(fault_input_pin_i)))
    else $error("fault output wrong for this instance");
  AST_FAULT_MASK: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ8
    fault_o |=> match_pin_o == '0)
    else $error("match outputs active during fault");

  // master side period handling
  AST_MASTER_END: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ11
    seq_master_end |=> s_r.cnt == `PWMSS_CNT_ZERO)
    else $error("counter did not restart at period end");
  AST_MASTER_COPY: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ2
    seq_master_end ##0 upd_req_i |=> s_r.per_sh == $past(period_i))
    else $error("master shadow copy missing");
  AST_PRE_WRAP: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ11
    pre_tick && !restart |=> s_r.pre == `PWMSS_CNT_ZERO)
    else $error("prescaler did not wrap");
  AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ1
    s_r.st == PWMSS_IDLE && !restart |=> !sync_o.start)
    else $error("start pulse without restart");

  // delay path: a restart arms the counter, the last count fires start, and load if pend_load is set
  AST_RETRIGGER: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ3
    restart && sync_dly_i != `PWMSS_CNT_ZERO
    |=> s_r.st == PWMSS_WAIT && s_r.dly == $past(sync_dly_i))
    else $error("delay not armed");
  AST_DLY_QUIET: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ3
    s_r.st == PWMSS_WAIT && s_r.dly != `PWMSS_CNT_ONE && !restart |=> !sync_o.start)
    else $error("start pulse before delay ran out");
  AST_DLY_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ2 RQ3
    s_r.st == PWMSS_WAIT && s_r.dly == `PWMSS_CNT_ONE && !restart
    |=> sync_o.start && sync_o.load == $past(s_r.pend_load))
    else $error("delayed pulses wrong");

  // slave side
  AST_SLAVE_NOCOPY: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ5
    seq_slave_start ##0 !sync_i.load |=> $stable(s_r.per_sh))
    else $error("slave copied without load pulse");
  AST_SLAVE_LOAD_OUT: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ5 RQ6
    seq_slave_start ##0 sync_i.load && sync_dly_i == `PWMSS_CNT_ZERO |=> sync_o.load)
    else $error("slave did not pass load pulse on");

  // capture on rising pin edges only
  AST_CAP0: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ7
    capture_pin_i[0] && !s_r.cap_d[0] |=> cap_val_o[0] == $past(s_r.cnt))
    else $error("capture 0 value wrong");
  AST_CAP1: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ7
    capture_pin_i[1] && !s_r.cap_d[1] |=> cap_val_o[1] == $past(s_r.cnt))
    else $error("capture 1 value wrong");
  AST_CAP2: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ7
    capture_pin_i[2] && !s_r.cap_d[2] |=> cap_val_o[2] == $past(s_r.cnt))
    else $error("capture 2 value wrong");
  AST_CAP_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ7
    capture_pin_i == s_r.cap_d |=> $stable(cap_val_o))
    else $error("capture value changed without edge");
endmodule : pwmss_core

// >>> tb/pwmss_up_model.sv
// upstream neighbour: one-cycle start/load pulses on request
// assumes the bench asks for one pulse at a time
`timescale 1ns/1ps
module pwmss_up_model
  import pwmss_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic fire_i,
  input wire logic load_i,
  output pwmss_sync_t sync_o
);
  always_ff @(posedge clk_i) begin
    if (!nrst_i) sync_o <= 2'h0;
    else begin
      sync_o.start <= fire_i;
      sync_o.load <= fire_i & load_i;
    end
  end
endmodule : pwmss_up_model

// >>> tb/testbench.sv
// bench: slave delay rows, ignored sync, master period, fault
// assumes the upstream model feeds sync_i
`timescale 1ns/1ps
module testbench
  import pwmss_pkg::*;
;
  typedef struct packed {logic [15:0] d; logic l;} pwmss_row_t;
  pwmss_row_t rows [4] = '{'{16'h0000, 1'b1}, '{16'h0001, 1'b0},
    '{16'h0003, 1'b1}, '{16'h0002, 1'b0}};
  logic clk = 0, nrst = 0, run = 0, slv = 0, upd = 0, fire = 0, ld = 0, flt = 0, l, flt_o;
  logic [15:0] dly = 16'h0000, presc = 16'h0000, period = 16'h0000;
  logic [5:0][15:0] rise = '0, fall = '0;
  logic [5:0] match, m, m0;
  logic [2:0] cap = 3'h0;
  logic [2:0][15:0] capv;
  pwmss_sync_t up, sync_o;
  int miscompares = 0, tests_run = 0, n, b;
  pwmss_up_model UP (.clk_i(clk), .nrst_i(nrst), .fire_i(fire), .load_i(ld), .sync_o(up));
  pwmss_core #(.INST(2)) DUT (.clk_i(clk), .nrst_i(nrst), .run_i(run), .slave_en_i(slv),
    .upd_req_i(upd), .sync_dly_i(dly), .presc_i(presc), .period_i(period), .rise_i(rise),
    .fall_i(fall), .sync_i(up), .capture_pin_i(cap), .fault_input_pin_i(flt),
    .sync_o(sync_o), .match_pin_o(match), .cap_val_o(capv), .fault_o(flt_o));
  initial forever #2 clk = ~clk;
  task automatic conclude();
    $display("checks %0d, wrong %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // bounded wait for a start pulse, then its width
  task automatic grab(output int k, output logic ll);
    k = -1;
    for (int i = 0; i < 40 && k < 0; i++) begin
      @(negedge clk);
      if (sync_o.start === 1'b1) begin
        k = i;
        ll = sync_o.load;
      end
    end
    if (k < 0) begin
      chk(1'b0, "no start pulse");
      conclude();
    end
    @(negedge clk);
    chk(sync_o.start === 1'b0, "start pulse too wide");
  endtask : grab
  task automatic pulse(input logic ll);
    @(posedge clk);
    fire <= 1'b1;
    ld <= ll;
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    presc <= 16'hFFFF;
    period <= 16'hFFFF;
    slv <= 1'b1;
    run <= 1'b1;
    @(negedge clk);
    chk(sync_o === 2'h0 && match === 6'h00 && flt_o === 1'b0, "reset state");
    foreach (rows[i]) begin
      @(posedge clk);
      dly <= rows[i].d;
      pulse(rows[i].l);
      grab(n, l);
      if (i == 0) b = n;
      chk(b <= 2 && n == b + rows[i].d, "sync delay");
      chk(l === rows[i].l, "slave load");
    end
    // disabled slave must not follow the neighbour
    @(posedge clk);
    slv <= 1'b0;
    pulse(1'b1);
    repeat (20) begin
      @(negedge clk);
      chk(sync_o.start === 1'b0, "sync followed while disabled");
    end
    @(posedge clk);
    nrst <= 1'b0;
    presc <= 16'h0000;
    period <= 16'h0003;
    upd <= 1'b1;
    dly <= 16'h0000;
    fall <= {6{16'h0002}};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) grab(n, l);
    chk(n == 2 && l === 1'b1, "master period and load");
    m = 6'h00;
    m0 = 6'h3F;
    repeat (8) begin
      @(negedge clk);
      m = m | match;
      m0 = m0 & match;
    end
    chk(m === 6'h3F, "outputs never high");
    chk(m0 === 6'h00, "outputs never low");
    @(posedge clk);
    upd <= 1'b0;
    repeat (3) grab(n, l);
    chk(l === 1'b0, "load without copy");
    // pins rise two counts after the restart, so every capture holds 2
    @(posedge clk);
    cap <= 3'h7;
    repeat (2) @(negedge clk);
    chk(capv === {3{16'h0002}}, "capture value");
    @(posedge clk);
    cap <= 3'h0;
    @(posedge clk);
    flt <= 1'b1;
    repeat (5) @(negedge clk);
    chk(flt_o === 1'b1 && match === 6'h00, "fault");
    conclude();
  end
endmodule : testbench
